//--- design/rtcc_calib_trickle.sv
`timescale 1ns/1ns
// What this block does
// [RULE_01] Each second is timed as 512 ticks of the 512 Hz tick, or 511 when short, 513 when long.
// [RULE_02] The correction magnitude sits in bits 4..0 of register 07h and its sign in bit 5.
// [RULE_03] Speeding shortens the first N seconds of one minute in every eight to 511 ticks.
// [RULE_04] Slowing lengthens the first N seconds of one minute in every sixteen to 513 ticks.
// [RULE_05] When speeding, the seven minutes after the corrected one use only 512-tick seconds.
// [RULE_06] When slowing, the fifteen minutes after the corrected one use only 512-tick seconds.
// [RULE_07] Sign 1 means speeding, sign 0 slowing, and a zero magnitude corrects nothing.
// [RULE_08] The frequency test output follows the raw tick and never the corrected seconds.
// [RULE_09] Software enables charging by writing unlock code 5h and setting the second switch bit.
// [RULE_10] The four-bit unlock code sits in bits 3..0 of register 09h.
// [RULE_11] The second switch bit sits in bit 5 of register 08h, apart from the unlock code.
// [RULE_12] The bypass control sits in bit 6 of register 09h and a 1 closes the bypass switch.
// [RULE_13] The bypass switch opens whenever the device runs from the backup supply.
// [RULE_14] On backup both charge switches open too and software must enable them again later.
// [RULE_15] The unlock switch closes only for the code whose four bits all differ from Ah.
// [RULE_16] After power-up the unlock code is Ah and the second switch and bypass bits are 0.
// [RULE_17] The first N seconds of a corrected minute are adjusted, phased by a free minute count.
module rtcc_calib_trickle (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tick_512hz,
  input wire logic on_backup,
  output logic freq_test_output,
  output logic logic_out,
  output logic second_pulse,
  output logic short_second,
  output logic long_second,
  output logic charge_sw1_close,
  output logic charge_sw2_close,
  output logic bypass_sw_close
);
  logic awready_ff;
  logic wready_ff;
  logic aw_held_ff;
  logic w_held_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic do_write;
  logic lane0;
  rtcc_pkg::rtcc_sel_e wsel;
  rtcc_pkg::rtcc_sel_e rsel;
  logic [31:0] nxt_rdata;
  logic out_bit_ff;
  logic freq_test_en_ff;
  logic calib_sign_ff;
  logic [4:0] calib_magnitude_ff;
  logic charge_second_switch_ff;
  logic diode_bypass_enable_ff;
  logic [3:0] charge_unlock_code_ff;
  logic freq_test_output_ff;
  logic sec_pulse;
  logic sec_short;
  logic sec_long;
  logic [5:0] sec_idx;
  logic [3:0] min_cnt;
  logic sw1_close;
  logic sw2_close;
  logic bypass_close;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign freq_test_output = freq_test_output_ff;
  assign logic_out = out_bit_ff;
  assign second_pulse = sec_pulse;
  assign short_second = sec_short;
  assign long_second = sec_long;
  assign charge_sw1_close = sw1_close;
  assign charge_sw2_close = sw2_close;
  assign bypass_sw_close = bypass_close;

  // ==========================================
  // write address and data capture
  assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wsel = rtcc_pkg::rtcc_decode(awaddr_ff);
  assign lane0 = do_write && wstrb_ff[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
    end
    else if (s_axi_awvalid && awready_ff)
    begin
      awready_ff <= 1'b0;
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held_ff <= 1'b0;
    else if (!aw_held_ff && !bvalid_ff)
      awready_ff <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (s_axi_wvalid && wready_ff)
    begin
      wready_ff <= 1'b0;
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (do_write)
      w_held_ff <= 1'b0;
    else if (!w_held_ff && !bvalid_ff)
      wready_ff <= 1'b1;
  end

  // ==========================================
  // write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= rtcc_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wsel == rtcc_pkg::SEL_NONE) ? rtcc_pkg::RESP_SLVERR : rtcc_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  // ==========================================
  // calibration register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_bit_ff <= 1'b1;
      freq_test_en_ff <= 1'b0;
      calib_sign_ff <= 1'b0;
      calib_magnitude_ff <= 5'h00;
    end
    else if (lane0 && wsel == rtcc_pkg::SEL_CALIB)
    begin
      out_bit_ff <= wdata_ff[rtcc_pkg::OUT_BIT];
      freq_test_en_ff <= wdata_ff[rtcc_pkg::FREQ_TEST_BIT];
      calib_sign_ff <= wdata_ff[rtcc_pkg::SIGN_BIT]; // RULE_02
      calib_magnitude_ff <= wdata_ff[rtcc_pkg::MAG_LSB +: rtcc_pkg::MAG_W]; // RULE_02
    end
  end

  // ==========================================
  // charge control fields
  always_ff @(posedge aclk)
  begin
    if (!aresetn || on_backup)
      charge_second_switch_ff <= 1'b0; // RULE_14 RULE_16
    else if (lane0 && wsel == rtcc_pkg::SEL_AUDIO)
      charge_second_switch_ff <= wdata_ff[rtcc_pkg::SW2_BIT]; // RULE_11
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || on_backup)
    begin
      diode_bypass_enable_ff <= 1'b0; // RULE_13 RULE_16
      charge_unlock_code_ff <= rtcc_pkg::UNLOCK_DEFAULT; // RULE_14 RULE_16
    end
    else if (lane0 && wsel == rtcc_pkg::SEL_CTRL2)
    begin
      diode_bypass_enable_ff <= wdata_ff[rtcc_pkg::BYPASS_BIT]; // RULE_12
      charge_unlock_code_ff <= wdata_ff[rtcc_pkg::UNLOCK_LSB +: rtcc_pkg::UNLOCK_W]; // RULE_10
    end
  end

  // ==========================================
  // read path
  assign rsel = rtcc_pkg::rtcc_decode(s_axi_araddr);

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    case (rsel)
      rtcc_pkg::SEL_CALIB:
      begin
        nxt_rdata[rtcc_pkg::OUT_BIT] = out_bit_ff;
        nxt_rdata[rtcc_pkg::FREQ_TEST_BIT] = freq_test_en_ff;
        nxt_rdata[rtcc_pkg::SIGN_BIT] = calib_sign_ff;
        nxt_rdata[rtcc_pkg::MAG_LSB +: rtcc_pkg::MAG_W] = calib_magnitude_ff;
      end
      rtcc_pkg::SEL_AUDIO:
        nxt_rdata[rtcc_pkg::SW2_BIT] = charge_second_switch_ff;
      rtcc_pkg::SEL_CTRL2:
      begin
        nxt_rdata[rtcc_pkg::BYPASS_BIT] = diode_bypass_enable_ff;
        nxt_rdata[rtcc_pkg::UNLOCK_LSB +: rtcc_pkg::UNLOCK_W] = charge_unlock_code_ff;
      end
      rtcc_pkg::SEL_STATUS:
      begin
        nxt_rdata[rtcc_pkg::STAT_SEC_LSB +: 6] = sec_idx;
        nxt_rdata[rtcc_pkg::STAT_MIN_LSB +: 4] = min_cnt;
        nxt_rdata[rtcc_pkg::STAT_SW1_BIT] = sw1_close;
        nxt_rdata[rtcc_pkg::STAT_SW2_BIT] = sw2_close;
        nxt_rdata[rtcc_pkg::STAT_BYP_BIT] = bypass_close;
        nxt_rdata[rtcc_pkg::STAT_BACKUP_BIT] = on_backup;
      end
      default:
        nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= rtcc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= (rsel == rtcc_pkg::SEL_NONE) ? rtcc_pkg::RESP_SLVERR : rtcc_pkg::RESP_OKAY;
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
    else if (!rvalid_ff)
      arready_ff <= 1'b1;
  end

  // ==========================================
  // frequency test from the raw tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      freq_test_output_ff <= 1'b0;
    else
      freq_test_output_ff <= freq_test_en_ff && tick_512hz; // RULE_08
  end

  // ==========================================
  // timebase and charge switches
  rtcc_sec_timebase u_timebase (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick_512hz(tick_512hz),
    .calib_sign(calib_sign_ff),
    .calib_magnitude(calib_magnitude_ff),
    .sec_pulse_ff(sec_pulse),
    .sec_short_ff(sec_short),
    .sec_long_ff(sec_long),
    .sec_idx_ff(sec_idx),
    .min_cnt_ff(min_cnt)
  );

  rtcc_charge_sw u_charge (
    .aclk(aclk),
    .aresetn(aresetn),
    .charge_unlock_code(charge_unlock_code_ff),
    .charge_second_switch(charge_second_switch_ff),
    .diode_bypass_enable(diode_bypass_enable_ff),
    .on_backup(on_backup),
    .sw1_close_ff(sw1_close),
    .sw2_close_ff(sw2_close),
    .bypass_close_ff(bypass_close)
  );

  // ==========================================
  // checks
  reset_defaults_a: assert property (@(posedge aclk) !aresetn |=> charge_unlock_code_ff
    == rtcc_pkg::UNLOCK_DEFAULT && !charge_second_switch_ff && !diode_bypass_enable_ff) // RULE_16
    else $error("charge fields not at defaults after reset");
  backup_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    on_backup |=> charge_unlock_code_ff == rtcc_pkg::UNLOCK_DEFAULT
    && !charge_second_switch_ff) // RULE_14
    else $error("charge fields kept on backup");
  freq_raw_a: assert property (@(posedge aclk) disable iff (!aresetn)
    freq_test_output_ff |-> $past(tick_512hz) && $past(freq_test_en_ff)) // RULE_08
    else $error("test output not from raw tick");
  calib_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lane0 && wsel == rtcc_pkg::SEL_CALIB |=> calib_magnitude_ff
    == $past(wdata_ff[rtcc_pkg::MAG_LSB +: rtcc_pkg::MAG_W])) // RULE_02
    else $error("magnitude not stored");
  unlock_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lane0 && wsel == rtcc_pkg::SEL_CTRL2 && !on_backup |=> charge_unlock_code_ff
    == $past(wdata_ff[rtcc_pkg::UNLOCK_LSB +: rtcc_pkg::UNLOCK_W])) // RULE_10
    else $error("unlock code not stored");
  resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_ff && !s_axi_bready |=> bvalid_ff && $stable(bresp_ff))
    else $error("write response dropped early");
  charge_pair_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sw1_close && sw2_close |-> $past(charge_unlock_code_ff) == rtcc_pkg::UNLOCK_OPEN_CODE
    && $past(charge_second_switch_ff)) // RULE_09
    else $error("charging without both controls");
  sw2_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_11
    lane0 && wsel == rtcc_pkg::SEL_AUDIO && !on_backup |=> charge_second_switch_ff
    == $past(wdata_ff[rtcc_pkg::SW2_BIT]))
    else $error("second switch bit not stored");
  bypass_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_12
    lane0 && wsel == rtcc_pkg::SEL_CTRL2 && !on_backup |=> diode_bypass_enable_ff
    == $past(wdata_ff[rtcc_pkg::BYPASS_BIT]))
    else $error("bypass bit not stored");
  sign_write_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_02
    lane0 && wsel == rtcc_pkg::SEL_CALIB |=> calib_sign_ff
    == $past(wdata_ff[rtcc_pkg::SIGN_BIT]))
    else $error("sign bit not stored");
  read_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_ff && !s_axi_rready |=> rvalid_ff && $stable(rdata_ff) && $stable(rresp_ff))
    else $error("read data dropped early");
  freq_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // RULE_08
    !freq_test_en_ff |=> !freq_test_output_ff)
    else $error("test output while disabled");
endmodule // rtcc_calib_trickle

//--- design/rtcc_pkg.sv
package rtcc_pkg;
  // ==========================================
  // second timebase
  localparam int unsigned TICK_W = 10;
  localparam logic [9:0] TICKS_NOMINAL = 10'h200;
  localparam logic [9:0] TICKS_SHORT = 10'h1FF;
  localparam logic [9:0] TICKS_LONG = 10'h201;
  localparam logic [9:0] TICK_ONE = 10'h001;
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [3:0] SPEED_PHASE_MASK = 4'h7;
  localparam logic [3:0] SLOW_PHASE_MASK = 4'hF;
  // ==========================================
  // register indices and byte addresses
  localparam logic [7:0] CALIB_IDX = 8'h07;
  localparam logic [7:0] AUDIO_IDX = 8'h08;
  localparam logic [7:0] CTRL2_IDX = 8'h09;
  localparam logic [7:0] CALIB_ADDR = CALIB_IDX << 2;
  localparam logic [7:0] AUDIO_ADDR = AUDIO_IDX << 2;
  localparam logic [7:0] CTRL2_ADDR = CTRL2_IDX << 2;
  localparam logic [7:0] STATUS_ADDR = 8'h28;
  // ==========================================
  // field positions
  localparam int unsigned OUT_BIT = 7;
  localparam int unsigned FREQ_TEST_BIT = 6;
  localparam int unsigned SIGN_BIT = 5;
  localparam int unsigned MAG_LSB = 0;
  localparam int unsigned MAG_W = 5;
  localparam int unsigned SW2_BIT = 5;
  localparam int unsigned BYPASS_BIT = 6;
  localparam int unsigned UNLOCK_LSB = 0;
  localparam int unsigned UNLOCK_W = 4;
  localparam int unsigned STAT_SEC_LSB = 0;
  localparam int unsigned STAT_MIN_LSB = 8;
  localparam int unsigned STAT_SW1_BIT = 16;
  localparam int unsigned STAT_SW2_BIT = 17;
  localparam int unsigned STAT_BYP_BIT = 18;
  localparam int unsigned STAT_BACKUP_BIT = 19;
  // ==========================================
  // reset and key values
  localparam logic [3:0] UNLOCK_DEFAULT = 4'hA;
  localparam logic [3:0] UNLOCK_OPEN_CODE = 4'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {SEL_NONE, SEL_CALIB, SEL_AUDIO, SEL_CTRL2, SEL_STATUS} rtcc_sel_e;
  // ==========================================
  // address decode
  function automatic rtcc_sel_e rtcc_decode(input logic [7:0] a);
    rtcc_sel_e s;
    s = SEL_NONE;
    if (a == CALIB_ADDR)
      s = SEL_CALIB;
    else if (a == AUDIO_ADDR)
      s = SEL_AUDIO;
    else if (a == CTRL2_ADDR)
      s = SEL_CTRL2;
    else if (a == STATUS_ADDR)
      s = SEL_STATUS;
    return s;
  endfunction
endpackage

//--- design/rtcc_sec_timebase.sv
`timescale 1ns/1ns
module rtcc_sec_timebase (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick_512hz,
  input wire logic calib_sign,
  input wire logic [4:0] calib_magnitude,
  output logic sec_pulse_ff,
  output logic sec_short_ff,
  output logic sec_long_ff,
  output logic [5:0] sec_idx_ff,
  output logic [3:0] min_cnt_ff
);
  logic [9:0] tick_cnt_ff;
  logic [9:0] gap_cnt_ff;
  logic [9:0] len;
  logic cur_short;
  logic cur_long;
  logic in_first_n;
  logic end_sec;

  // ==========================================
  // second length selection
  always_comb
  begin
    in_first_n = (calib_magnitude != 5'h00) && (sec_idx_ff < {1'b0, calib_magnitude}); // RULE_17
    cur_short = calib_sign && in_first_n
      && ((min_cnt_ff & rtcc_pkg::SPEED_PHASE_MASK) == 4'h0); // RULE_03
    cur_long = !calib_sign && in_first_n
      && ((min_cnt_ff & rtcc_pkg::SLOW_PHASE_MASK) == 4'h0); // RULE_04
    if (cur_short)
      len = rtcc_pkg::TICKS_SHORT; // RULE_07
    else if (cur_long)
      len = rtcc_pkg::TICKS_LONG;
    else
      len = rtcc_pkg::TICKS_NOMINAL; // RULE_05 RULE_06
    end_sec = tick_512hz && (tick_cnt_ff >= len - rtcc_pkg::TICK_ONE); // RULE_01
  end

  // ==========================================
  // tick counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt_ff <= 10'h000;
    else if (end_sec)
      tick_cnt_ff <= 10'h000;
    else if (tick_512hz)
      tick_cnt_ff <= tick_cnt_ff + rtcc_pkg::TICK_ONE;
  end

  // ==========================================
  // seconds and free-running minutes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec_idx_ff <= 6'h00;
      min_cnt_ff <= 4'h0;
    end
    else if (end_sec)
    begin
      if (sec_idx_ff == rtcc_pkg::SEC_LAST)
      begin
        sec_idx_ff <= 6'h00;
        min_cnt_ff <= min_cnt_ff + 4'h1; // RULE_17
      end
      else
        sec_idx_ff <= sec_idx_ff + 6'h01;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec_pulse_ff <= 1'b0;
      sec_short_ff <= 1'b0;
      sec_long_ff <= 1'b0;
    end
    else
    begin
      sec_pulse_ff <= end_sec;
      sec_short_ff <= end_sec && cur_short;
      sec_long_ff <= end_sec && cur_long;
    end
  end

  // ==========================================
  // checks
  always_ff @(posedge aclk)
  begin
    if (!aresetn || end_sec)
      gap_cnt_ff <= 10'h000;
    else if (tick_512hz)
      gap_cnt_ff <= gap_cnt_ff + rtcc_pkg::TICK_ONE;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sec_length_a: assert property (end_sec |-> gap_cnt_ff >= rtcc_pkg::TICKS_SHORT - rtcc_pkg::TICK_ONE
    && gap_cnt_ff <= rtcc_pkg::TICKS_LONG - rtcc_pkg::TICK_ONE) // RULE_01
    else $error("second length out of range");
  speed_minute_a: assert property (sec_short_ff |-> $past(calib_sign)
    && ($past(min_cnt_ff) & rtcc_pkg::SPEED_PHASE_MASK) == 4'h0) // RULE_05
    else $error("short second outside speeding minute");
  slow_minute_a: assert property (sec_long_ff |-> !$past(calib_sign)
    && $past(min_cnt_ff) == 4'h0) // RULE_06
    else $error("long second outside slowing minute");
  first_seconds_a: assert property ((sec_short_ff || sec_long_ff)
    |-> $past(sec_idx_ff) < {1'b0, $past(calib_magnitude)}) // RULE_17
    else $error("adjusted second beyond magnitude");
endmodule // rtcc_sec_timebase

//--- design/rtcc_charge_sw.sv
`timescale 1ns/1ns
module rtcc_charge_sw (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] charge_unlock_code,
  input wire logic charge_second_switch,
  input wire logic diode_bypass_enable,
  input wire logic on_backup,
  output logic sw1_close_ff,
  output logic sw2_close_ff,
  output logic bypass_close_ff
);
  // ==========================================
  // switch drive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sw1_close_ff <= 1'b0;
      sw2_close_ff <= 1'b0;
      bypass_close_ff <= 1'b0;
    end
    else
    begin
      sw1_close_ff <= !on_backup && (charge_unlock_code == rtcc_pkg::UNLOCK_OPEN_CODE); // RULE_15
      sw2_close_ff <= !on_backup && charge_second_switch; // RULE_14
      bypass_close_ff <= !on_backup && diode_bypass_enable; // RULE_12 RULE_13
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  unlock_close_a: assert property (sw1_close_ff |-> !$past(on_backup)
    && $past(charge_unlock_code) == rtcc_pkg::UNLOCK_OPEN_CODE) // RULE_15
    else $error("unlock switch closed without code");
  backup_open_a: assert property (on_backup |=> !sw1_close_ff && !sw2_close_ff
    && !bypass_close_ff) // RULE_13
    else $error("switch closed on backup");
  bypass_follow_a: assert property (diode_bypass_enable && !on_backup |=> bypass_close_ff) // RULE_12
    else $error("bypass did not close");
endmodule // rtcc_charge_sw

//--- tb/tb_rtc_calibration_trickle_ctrl.sv
`timescale 1ns/1ns
module tb_rtc_calibration_trickle_ctrl;
  // ==========================================
  // signals
  logic aclk = 1'b0, aresetn = 1'b0, on_backup = 1'b0, tick_512hz = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic freq_test_output, logic_out, second_pulse, short_second, long_second;
  logic charge_sw1_close, charge_sw2_close, bypass_sw_close;
  logic tick_run = 1'b0, freq_on = 1'b0, tick_d = 1'b0;
  logic [9:0] tick_cnt = 10'h000;
  logic [33:0] exp_q[$];
  logic [11:0] sec_q[$];
  logic [3:0] code;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;

  always #5 aclk = ~aclk;

  rtcc_calib_trickle i_rtcc_calib_trickle (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tick_512hz(tick_512hz),
    .on_backup(on_backup), .freq_test_output(freq_test_output), .logic_out(logic_out),
    .second_pulse(second_pulse), .short_second(short_second), .long_second(long_second),
    .charge_sw1_close(charge_sw1_close), .charge_sw2_close(charge_sw2_close),
    .bypass_sw_close(bypass_sw_close)
  );

  // ==========================================
  // report
  task automatic close_out();
    if (bad_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      bad_count++;
      close_out();
    end
  end

  // ==========================================
  // tick source and monitor
  always @(posedge aclk)
    tick_512hz <= tick_run && ($urandom() % 4 != 0);

  always @(posedge aclk)
  begin
    tick_d <= tick_512hz;
    if (!aresetn)
      tick_cnt <= 10'h000;
    else
    begin
      tick_cnt <= second_pulse ? {9'h0, tick_512hz} : tick_cnt + {9'h0, tick_512hz};
      if (s_axi_bvalid && s_axi_bready)
        cmp({s_axi_bresp, 32'h0}, exp_q.pop_front());
      if (s_axi_rvalid && s_axi_rready)
        cmp({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      if (second_pulse)
        cmp({22'h0, long_second, short_second, tick_cnt}, {22'h0, sec_q.pop_front()});
      cmp({33'h0, freq_test_output}, {33'h0, freq_on & tick_d});
    end
  end

  // ==========================================
  // drivers
  task automatic do_reset();
    aresetn <= 1'b0;
    freq_on <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s, input logic [1:0] r);
    logic [31:0] rnd;
    logic aw_ok;
    logic w_ok;
    rnd = $urandom();
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {rnd[31:8], d};
    s_axi_wstrb <= {rnd[3:1], s};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_axi_awready)
        aw_ok = 1'b1;
      if (s_axi_wready)
        w_ok = 1'b1;
      if (aw_ok)
        s_axi_awvalid <= 1'b0;
      if (w_ok)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_sw(input logic [2:0] e);
    repeat (2) @(posedge aclk);
    cmp({31'h0, charge_sw1_close, charge_sw2_close, bypass_sw_close}, {31'h0, e});
  endtask

  task automatic run_secs(input logic [7:0] cfg, input int n);
    int sec;
    int mn;
    logic sh;
    logic lg;
    wr(rtcc_pkg::CALIB_ADDR, cfg, 1'b1, rtcc_pkg::RESP_OKAY);
    rd(rtcc_pkg::CALIB_ADDR, {24'h0, cfg}, rtcc_pkg::RESP_OKAY);
    freq_on <= cfg[6];
    cmp({33'h0, logic_out}, {33'h0, cfg[7]});
    for (int i = 0; i < n; i++)
    begin
      sec = i % 60;
      mn = i / 60;
      sh = cfg[5] && (cfg[4:0] != 5'h00) && (mn % 8 == 0) && (sec < cfg[4:0]);
      lg = !cfg[5] && (cfg[4:0] != 5'h00) && (mn % 16 == 0) && (sec < cfg[4:0]);
      sec_q.push_back({lg, sh, sh ? rtcc_pkg::TICKS_SHORT :
        (lg ? rtcc_pkg::TICKS_LONG : rtcc_pkg::TICKS_NOMINAL)});
    end
    tick_run <= 1'b1;
    while (sec_q.size() != 0) @(posedge aclk);
    tick_run <= 1'b0;
    do_reset();
  endtask

  // ==========================================
  // main sequence
  initial
  begin
    void'($urandom(24));
    do_reset();
    rd(8'h1C, 32'h80, 2'h0);
    rd(8'h20, 32'h00, 2'h0);
    rd(8'h24, 32'h0A, 2'h0);
    rd(8'h40, 32'h00, rtcc_pkg::RESP_SLVERR);
    wr(8'h40, 8'hFF, 1'b1, rtcc_pkg::RESP_SLVERR);
    wr(8'h28, 8'hFF, 1'b1, 2'h0);
    rd(8'h28, 32'h00, 2'h0);
    cmp({33'h0, logic_out}, {33'h0, 1'b1});
    chk_sw(3'b000);
    wr(8'h20, 8'h20, 1'b1, 2'h0);
    for (int c = 0; c < 16; c++)
    begin
      code = c[3:0];
      wr(8'h24, {1'b0, code[0], 2'b00, code}, 1'b1, 2'h0);
      rd(8'h24, {25'h0, code[0], 2'b00, code}, 2'h0);
      chk_sw({code == rtcc_pkg::UNLOCK_OPEN_CODE, 1'b1, code[0]});
    end
    wr(8'h24, 8'h45, 1'b1, 2'h0);
    wr(8'h20, 8'h00, 1'b1, 2'h0);
    chk_sw(3'b101);
    wr(8'h20, 8'h20, 1'b0, 2'h0);
    chk_sw(3'b101);
    wr(8'h20, 8'h20, 1'b1, 2'h0);
    chk_sw(3'b111);
    on_backup <= 1'b1;
    chk_sw(3'b000);
    wr(8'h24, 8'h45, 1'b1, 2'h0);
    rd(8'h24, 32'h0A, 2'h0);
    rd(8'h20, 32'h00, 2'h0);
    rd(8'h28, 32'h0008_0000, 2'h0);
    on_backup <= 1'b0;
    chk_sw(3'b000);
    wr(8'h24, 8'h45, 1'b1, 2'h0);
    wr(8'h20, 8'h20, 1'b1, 2'h0);
    chk_sw(3'b111);
    do_reset();
    run_secs(8'hFF, 64);
    run_secs(8'h02, 4);
    run_secs(8'h60, 3);
    close_out();
  end
endmodule // tb_rtc_calibration_trickle_ctrl
